//--- tb.sv
`timescale 1ns/1ps
module tb;
  import tlirq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, alert_n, rd_done;
  logic [NUM_GPIO-1:0] gpio = '0;
  logic [NUM_REG-1:0] oc = '0, uv = '0, sd_en = '0, sd;
  logic [TEMP_W-1:0] tv = '0, tl = 10'h0c8;
  logic [NUM_BLK-1:0] blk = '0;
  logic [NUM_GROUP-1:0] prim;
  logic [EV_W-1:0] rd_flags, r, e;
  tlirq_access_type acc;
  tlirq_view_type view;
  logic [1:0] grp;
  logic [EV_W-1:0] expq[$];
  int error_cnt = 0, check_count = 0, seed = 88848, k;
  always #12.5 clk = ~clk;
  tlirq_ctrl uut (.clk(clk), .rst(rst), .gpio_pin(gpio),
    .reg_overcurrent(oc), .reg_undervolt(uv), .temp_value(tv),
    .blk_event(blk), .temp_warn_level(tl), .fault_shutdown_en(sd_en),
    .host_access(acc), .view_group(grp), .view(view), .primary(prim),
    .reg_shutdown(sd), .alert_n(alert_n));
  tlirq_host host (.clk(clk), .view(view), .acc(acc), .grp(grp),
    .rd_done(rd_done), .rd_flags(rd_flags));
  task automatic check(input string n, input logic [EV_W-1:0] x, y);
    check_count++;
    if (x !== y) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_done === 1'b1)
      check("flags", expq.pop_front(), rd_flags);
  end
  task automatic rd(input logic [1:0] g, input logic [EV_W-1:0] x);
    expq.push_back(x);
    host.get(g);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    wt(2);
    rst = 1'b0;
    rd(0, FLAG_RESET);
    check("mask", MASK_RESET, view.mask);
    check("alert_n", 16'h0001, {15'h0, alert_n});
    for (int g = 0; g < 4; g++) host.put(1'b1, 2'(g), 16'h0000);
    r = (16'($random(seed)) & 16'h0fff) | 16'h0001;
    gpio = r[11:0];
    wt(5);
    rd(0, r);
    rd(0, r);
    check("primary", 16'h0001, {15'h0, prim[0]});
    check("alert_n", 16'h0000, {15'h0, alert_n});
    host.put(1'b0, 2'h0, r & 16'h00ff);
    host.put(1'b0, 2'h0, 16'h0000);
    rd(0, r & 16'h0f00);
    host.put(1'b1, 2'h0, 16'hffff);
    check("primary", 16'h0000, {15'h0, prim[0]});
    host.put(1'b0, 2'h0, 16'hffff);
    gpio = '0;
    wt(4);
    rd(0, r);
    host.put(1'b1, 2'h0, 16'hfffe);
    check("primary", 16'h0001, {15'h0, prim[0]});
    host.put(1'b1, 2'h0, 16'hffff);
    host.put(1'b0, 2'h0, 16'hffff);
    k = int'($unsigned($random(seed)) % 14) + 1;
    sd_en = NUM_REG'(1) << k;
    oc = sd_en;
    uv = 15'h0001;
    wt(4);
    oc = '0;
    uv = '0;
    wt(3);
    e = (16'h0001 << k) | 16'h0001;
    rd(1, e);
    check("shutdown", {1'b0, sd_en}, {1'b0, sd});
    tv = 10'h0fa;
    blk = 4'h8;
    wt(5);
    blk = '0;
    rd(2, 16'h0001);
    rd(3, 16'h0008);
    check("primary", 16'h000e, {12'h0, prim});
    for (int g = 1; g < 4; g++) host.put(1'b0, 2'(g), 16'hffff);
    wt(2);
    check("alert_n", 16'h0001, {15'h0, alert_n});
    end_of_test();
  end
endmodule

//--- tlirq_ctrl.sv
`timescale 1ns/1ps
module tlirq_ctrl
  import tlirq_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Event sources
  input  wire logic [NUM_GPIO-1:0]     gpio_pin,
  input  wire logic [NUM_REG-1:0]      reg_overcurrent,
  input  wire logic [NUM_REG-1:0]      reg_undervolt,
  input  wire logic [TEMP_W-1:0]       temp_value,
  input  wire logic [NUM_BLK-1:0]      blk_event,
  // Programming from the host side
  input  wire logic [TEMP_W-1:0]       temp_warn_level,
  input  wire logic [NUM_REG-1:0]      fault_shutdown_en,
  input  wire tlirq_access_type        host_access,
  input  wire logic [1:0]              view_group,
  // Status
  output tlirq_view_type               view,
  output logic [NUM_GROUP-1:0]         primary,
  output logic [NUM_REG-1:0]           reg_shutdown,
  output logic                         alert_n
);

  // Refuse layouts whose groups do not fit one flag word
  if (NUM_GPIO > EV_W || NUM_REG > EV_W || NUM_BLK > EV_W) begin : g_bad_w
    $error("tlirq_ctrl: event group wider than flag word");
  end

  // Pins and analog monitors are asynchronous to clk
  logic [NUM_GPIO-1:0] gpio_s1, gpio_s2, gpio_d;
  logic [NUM_REG-1:0]  oc_s1, oc_s2, uv_s1, uv_s2;
  logic [NUM_BLK-1:0]  blk_s1, blk_s2;
  logic                temp_hot, temp_hot_d;
  // Pins may idle high; no edge until the delay line holds real samples
  logic                gpio_arm_s1, gpio_arm_s2, gpio_arm_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_s1 <= '0;
      gpio_s2 <= '0;
      gpio_d  <= '0;
      oc_s1   <= '0;
      oc_s2   <= '0;
      uv_s1   <= '0;
      uv_s2   <= '0;
      blk_s1  <= '0;
      blk_s2  <= '0;
      gpio_arm_s1 <= 1'b0;
      gpio_arm_s2 <= 1'b0;
      gpio_arm_d  <= 1'b0;
    end else begin
      gpio_s1 <= gpio_pin;
      gpio_s2 <= gpio_s1;
      gpio_d  <= gpio_s2;
      oc_s1   <= reg_overcurrent;
      oc_s2   <= oc_s1;
      uv_s1   <= reg_undervolt;
      uv_s2   <= uv_s1;
      blk_s1  <= blk_event;
      blk_s2  <= blk_s1;
      gpio_arm_s1 <= 1'b1;
      gpio_arm_s2 <= gpio_arm_s1;
      gpio_arm_d  <= gpio_arm_s2;
    end
  end

  // Temperature word comes from an on-clock converter; edge only
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_hot   <= 1'b0;
      temp_hot_d <= 1'b0;
    end else begin
      temp_hot   <= (temp_value >= temp_warn_level);
      temp_hot_d <= temp_hot;
    end
  end

  // Event vectors per group
  logic [EV_W-1:0] ev [NUM_GROUP];
  always_comb begin
    for (int g = 0; g < NUM_GROUP; g++) ev[g] = '0;
    ev[GRP_GPIO][NUM_GPIO-1:0]  = (gpio_s2 ^ gpio_d) &
                                  {NUM_GPIO{gpio_arm_d}};
    ev[GRP_FAULT][NUM_REG-1:0]  = oc_s2 | uv_s2;
    ev[GRP_TEMP][0]             = temp_hot & ~temp_hot_d;
    ev[GRP_BLK][NUM_BLK-1:0]    = blk_s2;
  end

  logic [EV_W-1:0] flag [NUM_GROUP];
  logic [EV_W-1:0] mask [NUM_GROUP];
  logic [EV_W-1:0] used [NUM_GROUP];

  always_comb begin
    for (int g = 0; g < NUM_GROUP; g++) used[g] = '0;
    used[GRP_GPIO][NUM_GPIO-1:0] = '1;
    used[GRP_FAULT][NUM_REG-1:0] = '1;
    used[GRP_TEMP][0]            = 1'b1;
    used[GRP_BLK][NUM_BLK-1:0]   = '1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUP; gi++) begin : g_grp
      logic sel;
      logic [EV_W-1:0] clr;
      assign sel = (host_access.group == 2'(gi));
      assign clr = (host_access.flag_wr && sel) ? host_access.data : '0;

      // Set wins over a simultaneous clear
      always_ff @(posedge clk) begin
        if (rst) begin
          flag[gi] <= FLAG_RESET;
        end else begin
          flag[gi] <= ((flag[gi] & ~clr) | ev[gi]) & used[gi];
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          mask[gi] <= MASK_RESET;
        end else if (host_access.mask_wr && sel) begin
          mask[gi] <= host_access.data;
        end
      end

      // Mask bit high blocks the flag from its primary
      assign primary[gi] = |(flag[gi] & ~mask[gi]);

      property p_hold;
        @(posedge clk) disable iff (rst)
          (flag[gi] != '0 && !(host_access.flag_wr && sel))
          |=> ((flag[gi] & $past(flag[gi])) == $past(flag[gi]));
      endproperty
      a_hold: assert property (p_hold)
        else $error("secondary flag dropped without a clear");
      property p_clear;
        @(posedge clk) disable iff (rst)
          (host_access.flag_wr && sel)
          |=> ((flag[gi] & ~$past(ev[gi]) & $past(host_access.data)) == '0);
      endproperty
      a_clear: assert property (p_clear)
        else $error("secondary flag survived a write of one");
      property p_set;
        @(posedge clk) disable iff (rst)
          1'b1 |=> ((($past(ev[gi]) & used[gi]) & ~flag[gi]) == '0);
      endproperty
      a_set: assert property (p_set)
        else $error("event did not set its secondary flag");
    end
  endgenerate

  // Programmable fault action: latch regulator off while flag stands
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_shutdown <= ACT_RESET;
    end else begin
      reg_shutdown <= flag[GRP_FAULT][NUM_REG-1:0] & fault_shutdown_en;
    end
  end

  property p_shutdown;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (reg_shutdown ==
        $past(flag[GRP_FAULT][NUM_REG-1:0] & fault_shutdown_en));
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown request disagrees with fault flags");

  // Read path is side-effect free
  always_ff @(posedge clk) begin
    if (rst) begin
      view <= '0;
    end else begin
      view.flags <= flag[view_group];
      view.mask  <= mask[view_group];
    end
  end

  assign alert_n = ~(|primary);

  property p_alert;
    @(posedge clk) disable iff (rst)
      (alert_n == 1'b0) == (primary != '0);
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert pin disagrees with primary flags");

  sequence s_gpio_edge;
    $changed(gpio_s2) && gpio_arm_d && !(host_access.flag_wr &&
      host_access.group == 2'(GRP_GPIO));
  endsequence
  property p_gpio;
    @(posedge clk) disable iff (rst)
      s_gpio_edge ##1 1'b1 |-> (flag[GRP_GPIO][NUM_GPIO-1:0] != '0);
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("pin edge did not set a pin flag");

  property p_masked;
    @(posedge clk) disable iff (rst)
      (mask[GRP_BLK] == '1) |-> !primary[GRP_BLK];
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked block group reached its primary");

  property p_temp;
    @(posedge clk) disable iff (rst)
      $rose(temp_hot) |=> flag[GRP_TEMP][0];
  endproperty
  a_temp: assert property (p_temp)
    else $error("warning crossing did not set its flag");

  property p_view;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (view.flags == $past(flag[view_group]));
  endproperty
  a_view: assert property (p_view)
    else $error("view does not show the selected flags");
endmodule

//--- tlirq_host.sv
`timescale 1ns/1ps
module tlirq_host
  import tlirq_pkg::*;
(
  // Clock and device view
  input  wire logic           clk,
  input  wire tlirq_view_type view,
  // Host requests
  output tlirq_access_type    acc,
  output logic [1:0]          grp,
  output logic                rd_done,
  output logic [EV_W-1:0]     rd_flags
);
  initial begin
    acc = '0;
    grp = 2'h0;
    rd_done = 1'b0;
    rd_flags = '0;
  end
  // One-cycle strobe; m picks mask write over flag clear
  task automatic put(input logic m, input logic [1:0] g,
                     input logic [EV_W-1:0] d);
    @(posedge clk);
    #1;
    acc = '{~m, m, g, d};
    @(posedge clk);
    #1;
    acc = '0;
  endtask
  // View is registered, so wait an extra edge
  task automatic get(input logic [1:0] g);
    @(posedge clk);
    #1;
    grp = g;
    repeat (2) @(posedge clk);
    #1;
    rd_flags = view.flags;
    rd_done = 1'b1;
    @(posedge clk);
    #1;
    rd_done = 1'b0;
  endtask
endmodule

//--- tlirq_pkg.sv
package tlirq_pkg;
  // Event group layout
  localparam int NUM_GPIO  = 12;
  localparam int NUM_REG   = 15;
  localparam int NUM_BLK   = 4;
  localparam int TEMP_W    = 10;
  localparam int NUM_GROUP = 4;
  localparam int GRP_GPIO  = 0;
  localparam int GRP_FAULT = 1;
  localparam int GRP_TEMP  = 2;
  localparam int GRP_BLK   = 3;
  localparam int EV_W      = 16;
  localparam logic [EV_W-1:0] FLAG_RESET = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RESET = 16'hffff;
  localparam logic [NUM_REG-1:0] ACT_RESET = 15'h0000;

  // Host-side access to one group's flags or mask
  typedef struct packed {
    logic                    flag_wr;
    logic                    mask_wr;
    logic [1:0]              group;
    logic [EV_W-1:0]         data;
  } tlirq_access_type;

  typedef struct packed {
    logic [EV_W-1:0]         flags;
    logic [EV_W-1:0]         mask;
  } tlirq_view_type;
endpackage
